// *** verilog/cpu_instruction_class_decoder.sv ***
// Decode and execute stage for the bit, shift, move, stack, flow and system classes
`timescale 1ns/1ps
`default_nettype none
`include "cpu_class_map.svh"
module cpu_instruction_class_decoder
  import cpu_class_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic          ref_clk_i,
  input  wire logic          rst_n_i,
  input  wire logic          clk_en_i,
  input  wire logic          instr_valid_i,
  input  wire logic [31:0]   instr_i,
  input  wire logic [W-1:0]  src_word_i,
  input  wire logic [W-1:0]  aux_word_i,
  input  wire logic          test_bit_i,
  input  wire logic          src_bit_i,
  input  wire logic          cond_ok_i,
  input  wire logic [15:0]   ip_i,
  input  wire logic [7:0]    csp_i,
  input  wire logic [15:0]   stack_top0_i,
  input  wire logic [15:0]   stack_top1_i,
  output logic               done_o,
  output logic               illegal_trap_o,
  output logic [W-1:0]       result_o,
  output logic               result_we_o,
  output logic               bit_val_o,
  output logic               bit_we_o,
  output logic               ip_load_o,
  output logic [15:0]        ip_new_o,
  output logic               csp_load_o,
  output logic [7:0]         csp_new_o,
  output logic               push_a_o,
  output logic [15:0]        push_a_data_o,
  output logic               push_b_o,
  output logic [15:0]        push_b_data_o,
  output logic [1:0]         pop_cnt_o,
  output logic               sw_reset_o,
  output logic               idle_o,
  output logic               power_down_o,
  output logic               watchdog_service_o,
  output logic               watchdog_disable_o,
  output logic               reset_output_pin_o,
  output logic               ext_space_o,
  output logic               page_override_o,
  output logic [9:0]         page_sel_o,
  output logic               seg_override_o,
  output logic [7:0]         seg_sel_o,
  output logic               atomic_o
);

  function automatic op_class_e prot_check(input logic [31:0] w, input logic [31:0] pat,
                                           input op_class_e hit);
    prot_check = (w == pat) ? hit : OP_ILLEGAL;
  endfunction

  function automatic op_class_e decode_op(input logic [31:0] w);
    decode_op = OP_NONE;
    case (w[7:0])
      `OPC_BIT_MOVE:     decode_op = OP_BIT_MOVE;
      `OPC_BIT_MOVE_NEG: decode_op = OP_BIT_MOVE_N;
      `OPC_SHIFT_RIGHT,
      `OPC_SHIFT_LEFT,
      `OPC_ROT_RIGHT,
      `OPC_ROT_LEFT,
      `OPC_ASHIFT_RIGHT: decode_op = OP_SHIFT;
      `OPC_NORM_COUNT:   decode_op = OP_NORM;
      `OPC_MOVE_SEXT:    decode_op = OP_MOVE_SEXT;
      `OPC_MOVE_ZEXT:    decode_op = OP_MOVE_ZEXT;
      `OPC_SWITCH_CTX:   decode_op = OP_SWITCH_CTX;
      `OPC_JUMP_SET:     decode_op = OP_JUMP_SET;
      `OPC_JUMP_CLR:     decode_op = OP_JUMP_CLR;
      `OPC_JUMP_SET_CLR: decode_op = OP_JUMP_SETCLR;
      `OPC_JUMP_CLR_SET: decode_op = OP_JUMP_CLRSET;
      `OPC_JUMP_SEG:     decode_op = OP_JUMP_SEG;
      `OPC_CALL_ABS:     decode_op = OP_CALL_ABS;
      `OPC_CALL_IND:     decode_op = OP_CALL_IND;
      `OPC_CALL_REL:     decode_op = OP_CALL_REL;
      `OPC_CALL_SEG:     decode_op = OP_CALL_SEG;
      `OPC_CALL_PUSH:    decode_op = OP_CALL_PUSH;
      `OPC_SW_TRAP:      decode_op = OP_SW_TRAP;
      `OPC_RETURN:       decode_op = OP_RETURN;
      `OPC_RETURN_SEG:   decode_op = OP_RETURN_SEG;
      `OPC_RETURN_POP:   decode_op = OP_RETURN_POP;
      `OPC_EXT_REG:      decode_op = OP_EXT_REG;
      `OPC_EXT_PAGE:     decode_op = OP_EXT_PAGE;
      `OPC_EXT_PAGE_ESP: decode_op = OP_EXT_PAGE_X;
      `OPC_EXT_SEG:      decode_op = OP_EXT_SEG;
      `OPC_EXT_SEG_ESP:  decode_op = OP_EXT_SEG_X;
      `OPC_ATOMIC_SEQ:   decode_op = OP_ATOMIC;
      `OPC_NULL_OP:      decode_op = OP_NULL;
      `OPC_SW_RESET:     decode_op = prot_check(w, `PAT_SW_RESET, OP_SW_RESET);
      `OPC_IDLE_MODE:    decode_op = prot_check(w, `PAT_IDLE_MODE, OP_IDLE_MODE);
      `OPC_POWER_DOWN:   decode_op = prot_check(w, `PAT_POWER_DOWN, OP_POWER_DOWN);
      `OPC_WDT_SERVICE:  decode_op = prot_check(w, `PAT_WDT_SERVICE, OP_WDT_SERVICE);
      `OPC_WDT_DISABLE:  decode_op = prot_check(w, `PAT_WDT_DISABLE, OP_WDT_DISABLE);
      `OPC_END_INIT:     decode_op = prot_check(w, `PAT_END_INIT, OP_END_INIT);
      default:           decode_op = OP_NONE;
    endcase
  endfunction

  op_class_e   op;
  shift_kind_e sh_kind;
  logic [W-1:0]          sh_result;
  logic [$clog2(W)-1:0]  norm_cnt;
  logic [15:0]           rel_tgt;
  logic [15:0]           abs_tgt;
  logic [15:0]           trap_tgt;
  logic                  prefix_op;
  logic [2:0]            scope_len;
  logic [2:0]            prefix_left_r;

  assign op        = decode_op(instr_i);
  assign rel_tgt   = ip_i + {{7{instr_i[`FLD_DISP_HI]}}, instr_i[`FLD_DISP_HI:`FLD_DISP_LO], 1'b0};
  assign abs_tgt   = instr_i[`FLD_ABS_HI:`FLD_ABS_LO];
  assign trap_tgt  = {6'h00, instr_i[`FLD_SEG_HI:`FLD_SEG_LO], 2'b00};
  assign scope_len = {1'b0, instr_i[`FLD_SCOPE_HI:`FLD_SCOPE_LO]} + 3'h1;
  assign prefix_op = (op == OP_EXT_REG) || (op == OP_EXT_PAGE) || (op == OP_EXT_PAGE_X) ||
                     (op == OP_EXT_SEG) || (op == OP_EXT_SEG_X) || (op == OP_ATOMIC);

  always_comb begin
    unique case (instr_i[7:0])
      `OPC_SHIFT_LEFT:   sh_kind = SH_LEFT;
      `OPC_ROT_RIGHT:    sh_kind = ROT_RIGHT;
      `OPC_ROT_LEFT:     sh_kind = ROT_LEFT;
      `OPC_ASHIFT_RIGHT: sh_kind = SH_ARITH;
      default:           sh_kind = SH_RIGHT;
    endcase
  end

  word_shifter #(.W(W)) u_shift (
    .data_i   (src_word_i),
    .cnt_i    (instr_i[`FLD_SHCNT_LO +: $clog2(W)]),
    .kind_i   (sh_kind),
    .result_o (sh_result)
  );

  normalise_counter #(.W(W)) u_norm (
    .data_i  (src_word_i),
    .count_o (norm_cnt)
  );

  // Completion and illegal-op pulses
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      done_o         <= 1'b0;
      illegal_trap_o <= 1'b0;
    end else if (clk_en_i) begin
      done_o         <= instr_valid_i && (op != OP_NONE) && (op != OP_ILLEGAL);
      illegal_trap_o <= instr_valid_i && (op == OP_ILLEGAL);
    end
  end

  // Word and bit results
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      result_o    <= '0;
      result_we_o <= 1'b0;
      bit_val_o   <= 1'b0;
      bit_we_o    <= 1'b0;
    end else if (clk_en_i) begin
      result_we_o <= 1'b0;
      bit_we_o    <= 1'b0;
      if (instr_valid_i) begin
        unique case (op)
          OP_SHIFT: begin
            result_o    <= sh_result;
            result_we_o <= 1'b1;
          end
          OP_NORM: begin
            result_o    <= W'(norm_cnt);
            result_we_o <= 1'b1;
          end
          OP_MOVE_SEXT: begin
            result_o    <= {{(W-8){src_word_i[7]}}, src_word_i[7:0]};
            result_we_o <= 1'b1;
          end
          OP_MOVE_ZEXT: begin
            result_o    <= {{(W-8){1'b0}}, src_word_i[7:0]};
            result_we_o <= 1'b1;
          end
          OP_SWITCH_CTX, OP_RETURN_POP: begin
            result_o    <= (op == OP_SWITCH_CTX) ? aux_word_i : W'(stack_top1_i);
            result_we_o <= 1'b1;
          end
          OP_BIT_MOVE, OP_BIT_MOVE_N: begin
            bit_val_o <= (op == OP_BIT_MOVE_N) ? ~src_bit_i : src_bit_i;
            bit_we_o  <= 1'b1;
          end
          OP_JUMP_SETCLR, OP_JUMP_CLRSET: begin
            bit_val_o <= ~test_bit_i;
            bit_we_o  <= (op == OP_JUMP_SETCLR) ? test_bit_i : ~test_bit_i;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Program flow: pointer and segment loads
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ip_load_o  <= 1'b0;
      ip_new_o   <= 16'h0000;
      csp_load_o <= 1'b0;
      csp_new_o  <= 8'h00;
    end else if (clk_en_i) begin
      ip_load_o  <= 1'b0;
      csp_load_o <= 1'b0;
      if (instr_valid_i) begin
        unique case (op)
          OP_JUMP_SET, OP_JUMP_SETCLR: begin
            ip_new_o  <= rel_tgt;
            ip_load_o <= test_bit_i;
          end
          OP_JUMP_CLR, OP_JUMP_CLRSET: begin
            ip_new_o  <= rel_tgt;
            ip_load_o <= ~test_bit_i;
          end
          OP_JUMP_SEG, OP_CALL_SEG: begin
            ip_new_o   <= abs_tgt;
            ip_load_o  <= 1'b1;
            csp_new_o  <= instr_i[`FLD_SEG_HI:`FLD_SEG_LO];
            csp_load_o <= 1'b1;
          end
          OP_CALL_ABS, OP_CALL_IND: begin
            ip_new_o  <= (op == OP_CALL_ABS) ? abs_tgt : aux_word_i[15:0];
            ip_load_o <= cond_ok_i;
          end
          OP_CALL_REL: begin
            ip_new_o  <= rel_tgt;
            ip_load_o <= 1'b1;
          end
          OP_CALL_PUSH: begin
            ip_new_o  <= abs_tgt;
            ip_load_o <= 1'b1;
          end
          OP_SW_TRAP: begin
            ip_new_o   <= trap_tgt;
            ip_load_o  <= 1'b1;
            csp_new_o  <= `TRAP_SEGMENT;
            csp_load_o <= 1'b1;
          end
          OP_RETURN, OP_RETURN_POP: begin
            ip_new_o  <= stack_top0_i;
            ip_load_o <= 1'b1;
          end
          OP_RETURN_SEG: begin
            ip_new_o   <= stack_top0_i;
            ip_load_o  <= 1'b1;
            csp_new_o  <= stack_top1_i[7:0];
            csp_load_o <= 1'b1;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // System stack traffic
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      push_a_o      <= 1'b0;
      push_a_data_o <= 16'h0000;
      push_b_o      <= 1'b0;
      push_b_data_o <= 16'h0000;
      pop_cnt_o     <= 2'h0;
    end else if (clk_en_i) begin
      push_a_o  <= 1'b0;
      push_b_o  <= 1'b0;
      pop_cnt_o <= 2'h0;
      if (instr_valid_i) begin
        unique case (op)
          OP_SWITCH_CTX, OP_CALL_PUSH: begin
            push_a_o      <= 1'b1;
            push_a_data_o <= src_word_i[15:0];
            push_b_o      <= (op == OP_CALL_PUSH);
            push_b_data_o <= ip_i;
          end
          OP_CALL_SEG, OP_SW_TRAP: begin
            push_a_o      <= 1'b1;
            push_a_data_o <= {8'h00, csp_i};
            push_b_o      <= 1'b1;
            push_b_data_o <= ip_i;
          end
          OP_CALL_ABS, OP_CALL_IND, OP_CALL_REL: begin
            push_a_o      <= (op == OP_CALL_REL) || cond_ok_i;
            push_a_data_o <= ip_i;
          end
          OP_RETURN:     pop_cnt_o <= 2'h1;
          OP_RETURN_SEG: pop_cnt_o <= 2'h2;
          OP_RETURN_POP: pop_cnt_o <= 2'h2;
          default: begin
          end
        endcase
      end
    end
  end

  // System control; the null op falls through with no effect
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_reset_o         <= 1'b0;
      idle_o             <= 1'b0;
      power_down_o       <= 1'b0;
      watchdog_service_o <= 1'b0;
      watchdog_disable_o <= 1'b0;
      reset_output_pin_o <= 1'b0;
    end else if (clk_en_i) begin
      sw_reset_o         <= instr_valid_i && (op == OP_SW_RESET);
      idle_o             <= instr_valid_i && (op == OP_IDLE_MODE);
      power_down_o       <= instr_valid_i && (op == OP_POWER_DOWN);
      watchdog_service_o <= instr_valid_i && (op == OP_WDT_SERVICE);
      watchdog_disable_o <= instr_valid_i && (op == OP_WDT_DISABLE) &&
                            !reset_output_pin_o;
      if (instr_valid_i && (op == OP_END_INIT)) begin
        reset_output_pin_o <= 1'b1;
      end
    end
  end

  // Addressing prefixes and atomic sequences, scoped to the next instructions
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prefix_left_r   <= 3'h0;
      ext_space_o     <= 1'b0;
      page_override_o <= 1'b0;
      page_sel_o      <= 10'h000;
      seg_override_o  <= 1'b0;
      seg_sel_o       <= 8'h00;
      atomic_o        <= 1'b0;
    end else if (clk_en_i && instr_valid_i) begin
      if (prefix_op) begin
        prefix_left_r <= scope_len;
        atomic_o      <= 1'b1;
        unique case (op)
          OP_EXT_REG: begin
            ext_space_o     <= 1'b1;
            page_override_o <= 1'b0;
            seg_override_o  <= 1'b0;
          end
          OP_EXT_PAGE, OP_EXT_PAGE_X: begin
            ext_space_o     <= (op == OP_EXT_PAGE_X);
            page_override_o <= 1'b1;
            page_sel_o      <= instr_i[`FLD_PAGE_HI:`FLD_PAGE_LO];
            seg_override_o  <= 1'b0;
          end
          OP_EXT_SEG, OP_EXT_SEG_X: begin
            ext_space_o     <= (op == OP_EXT_SEG_X);
            seg_override_o  <= 1'b1;
            seg_sel_o       <= instr_i[`FLD_OSEG_HI:`FLD_OSEG_LO];
            page_override_o <= 1'b0;
          end
          default: begin
          end
        endcase
      end else if (prefix_left_r != 3'h0) begin
        prefix_left_r <= prefix_left_r - 3'h1;
        if (prefix_left_r == 3'h1) begin
          ext_space_o     <= 1'b0;
          page_override_o <= 1'b0;
          seg_override_o  <= 1'b0;
          atomic_o        <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** verilog/cpu_class_map.svh ***
// Opcode, pattern, field and timing constants for the instruction class decoder
`ifndef CPU_CLASS_MAP_SVH
`define CPU_CLASS_MAP_SVH

// Regular opcodes, identified by the low byte only
`define OPC_BIT_MOVE      8'h10
`define OPC_BIT_MOVE_NEG  8'h11
`define OPC_SHIFT_RIGHT   8'h20
`define OPC_SHIFT_LEFT    8'h21
`define OPC_ROT_RIGHT     8'h22
`define OPC_ROT_LEFT      8'h23
`define OPC_ASHIFT_RIGHT  8'h24
`define OPC_NORM_COUNT    8'h28
`define OPC_MOVE_SEXT     8'h30
`define OPC_MOVE_ZEXT     8'h31
`define OPC_SWITCH_CTX    8'h38
`define OPC_JUMP_SET      8'h40
`define OPC_JUMP_CLR      8'h41
`define OPC_JUMP_SET_CLR  8'h42
`define OPC_JUMP_CLR_SET  8'h43
`define OPC_JUMP_SEG      8'h48
`define OPC_CALL_ABS      8'h50
`define OPC_CALL_IND      8'h51
`define OPC_CALL_REL      8'h52
`define OPC_CALL_SEG      8'h53
`define OPC_CALL_PUSH     8'h54
`define OPC_SW_TRAP       8'h58
`define OPC_RETURN        8'h60
`define OPC_RETURN_SEG    8'h61
`define OPC_RETURN_POP    8'h62
`define OPC_EXT_REG       8'h70
`define OPC_EXT_PAGE      8'h71
`define OPC_EXT_PAGE_ESP  8'h72
`define OPC_EXT_SEG       8'h73
`define OPC_EXT_SEG_ESP   8'h74
`define OPC_ATOMIC_SEQ    8'h78
`define OPC_NULL_OP       8'h7C

// Protected opcodes: low byte, and full doubleword that must match
`define OPC_SW_RESET      8'hB1
`define OPC_IDLE_MODE     8'hB2
`define OPC_POWER_DOWN    8'hB3
`define OPC_WDT_SERVICE   8'hB4
`define OPC_WDT_DISABLE   8'hB5
`define OPC_END_INIT      8'hB6
`define PAT_SW_RESET      32'h4EB14EB1
`define PAT_IDLE_MODE     32'h4DB24DB2
`define PAT_POWER_DOWN    32'h4CB34CB3
`define PAT_WDT_SERVICE   32'h4BB44BB4
`define PAT_WDT_DISABLE   32'h4AB54AB5
`define PAT_END_INIT      32'h49B649B6

// Field positions inside the doubleword
`define FLD_SHCNT_HI      11
`define FLD_SHCNT_LO      8
`define FLD_SCOPE_HI      13
`define FLD_SCOPE_LO      12
`define FLD_SEG_HI        15
`define FLD_SEG_LO        8
`define FLD_DISP_HI       31
`define FLD_DISP_LO       24
`define FLD_ABS_HI        31
`define FLD_ABS_LO        16
`define FLD_PAGE_HI       25
`define FLD_PAGE_LO       16
`define FLD_OSEG_HI       23
`define FLD_OSEG_LO       16

// Trap table lives in code segment 0, four bytes per vector
`define TRAP_SEGMENT      8'h00
`define EXEC_LATENCY      1

`endif

// *** verilog/cpu_class_pkg.sv ***
// Types shared by the instruction class decoder and its helpers
`default_nettype none
package cpu_class_pkg;

  typedef enum logic [5:0] {
    OP_NONE        = 6'b000000,
    OP_ILLEGAL     = 6'b000001,
    OP_SW_RESET    = 6'b000010,
    OP_IDLE_MODE   = 6'b000011,
    OP_POWER_DOWN  = 6'b000100,
    OP_WDT_SERVICE = 6'b000101,
    OP_WDT_DISABLE = 6'b000110,
    OP_END_INIT    = 6'b000111,
    OP_NULL        = 6'b001000,
    OP_BIT_MOVE    = 6'b001001,
    OP_BIT_MOVE_N  = 6'b001010,
    OP_SHIFT       = 6'b001011,
    OP_NORM        = 6'b001100,
    OP_MOVE_SEXT   = 6'b001101,
    OP_MOVE_ZEXT   = 6'b001110,
    OP_SWITCH_CTX  = 6'b001111,
    OP_JUMP_SET    = 6'b010000,
    OP_JUMP_CLR    = 6'b010001,
    OP_JUMP_SETCLR = 6'b010010,
    OP_JUMP_CLRSET = 6'b010011,
    OP_JUMP_SEG    = 6'b010100,
    OP_CALL_ABS    = 6'b010101,
    OP_CALL_IND    = 6'b010110,
    OP_CALL_REL    = 6'b010111,
    OP_CALL_SEG    = 6'b011000,
    OP_CALL_PUSH   = 6'b011001,
    OP_SW_TRAP     = 6'b011010,
    OP_RETURN      = 6'b011011,
    OP_RETURN_SEG  = 6'b011100,
    OP_RETURN_POP  = 6'b011101,
    OP_EXT_REG     = 6'b011110,
    OP_EXT_PAGE    = 6'b011111,
    OP_EXT_PAGE_X  = 6'b100000,
    OP_EXT_SEG     = 6'b100001,
    OP_EXT_SEG_X   = 6'b100010,
    OP_ATOMIC      = 6'b100011
  } op_class_e;

  typedef enum logic [2:0] {
    SH_RIGHT  = 3'b000,
    SH_LEFT   = 3'b001,
    ROT_RIGHT = 3'b010,
    ROT_LEFT  = 3'b011,
    SH_ARITH  = 3'b100
  } shift_kind_e;

endpackage
`default_nettype wire

// *** verilog/word_shifter.sv ***
// Combinational word shifter and rotator
`timescale 1ns/1ps
`default_nettype none
module word_shifter
  import cpu_class_pkg::*;
#(
  parameter int W = 16
) (
  input  wire logic [W-1:0]         data_i,
  input  wire logic [$clog2(W)-1:0] cnt_i,
  input  wire shift_kind_e          kind_i,
  output logic      [W-1:0]         result_o
);
  logic [2*W-1:0] dbl;
  logic [2*W-1:0] dbl_r;
  logic [2*W-1:0] dbl_l;

  always_comb begin
    dbl   = {data_i, data_i};
    dbl_r = dbl >> cnt_i;
    dbl_l = dbl << cnt_i;
    unique case (kind_i)
      SH_RIGHT:  result_o = data_i >> cnt_i;
      SH_LEFT:   result_o = data_i << cnt_i;
      ROT_RIGHT: result_o = dbl_r[W-1:0];
      ROT_LEFT:  result_o = dbl_l[2*W-1:W];
      SH_ARITH:  result_o = W'($signed(data_i) >>> cnt_i);
      default:   result_o = data_i;
    endcase
  end
endmodule
`default_nettype wire

// *** verilog/normalise_counter.sv ***
// Count of left shifts that brings the top set bit to the word's top
`timescale 1ns/1ps
`default_nettype none
module normalise_counter #(
  parameter int W = 16
) (
  input  wire logic [W-1:0]         data_i,
  output logic      [$clog2(W)-1:0] count_o
);
  logic found;
  logic [$clog2(W)-1:0] cnt;

  always_comb begin
    found = 1'b0;
    cnt   = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (!found) begin
        if (data_i[i]) begin
          found = 1'b1;
        end else begin
          cnt = cnt + 1'b1;
        end
      end
    end
    count_o = found ? cnt : '0;
  end
endmodule
`default_nettype wire

// *** testbench/cpu_class_chk.sv ***
// Assertion checker for the instruction class decoder
`timescale 1ns/1ps
`default_nettype none
`include "cpu_class_map.svh"
module cpu_class_chk #(
  parameter int W = 16
) (
  input wire logic         ref_clk_i,
  input wire logic         rst_n_i,
  input wire logic         clk_en_i,
  input wire logic         instr_valid_i,
  input wire logic [31:0]  instr_i,
  input wire logic [W-1:0] src_word_i,
  input wire logic         done_o,
  input wire logic         illegal_trap_o,
  input wire logic [W-1:0] result_o,
  input wire logic         result_we_o,
  input wire logic         bit_we_o,
  input wire logic         ip_load_o,
  input wire logic [15:0]  ip_new_o,
  input wire logic         csp_load_o,
  input wire logic [7:0]   csp_new_o,
  input wire logic         push_a_o,
  input wire logic [1:0]   pop_cnt_o,
  input wire logic         sw_reset_o,
  input wire logic         watchdog_disable_o,
  input wire logic         reset_output_pin_o,
  input wire logic         ext_space_o,
  input wire logic         page_override_o,
  input wire logic         seg_override_o,
  input wire logic         atomic_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire logic       go = instr_valid_i && clk_en_i;
  wire logic [7:0] op = instr_i[7:0];
  a_pin_stays_high: assert property ($past(reset_output_pin_o) |-> reset_output_pin_o)
    else $error("reset output pin fell");
  a_wdt_locked: assert property (reset_output_pin_o |-> !watchdog_disable_o)
    else $error("watchdog disable after init");
  a_reset_exact: assert property ($rose(sw_reset_o) |-> $past(instr_i) == `PAT_SW_RESET)
    else $error("reset without exact pattern");
  a_bad_pattern: assert property (go && op == `OPC_SW_RESET && instr_i != `PAT_SW_RESET
    |=> illegal_trap_o && !sw_reset_o && !done_o) else $error("broken pattern not trapped");
  a_illegal_cause: assert property ($rose(illegal_trap_o)
    |-> $past(instr_i[7:0]) inside {[8'hB1:8'hB6]}) else $error("illegal trap on regular op");
  a_null_quiet: assert property (go && op == `OPC_NULL_OP |=> done_o && !ip_load_o
    && !result_we_o && !bit_we_o && !push_a_o && pop_cnt_o == 2'h0) else $error("null op acted");
  a_sext_fill: assert property (go && op == `OPC_MOVE_SEXT |=> result_we_o
    && result_o == {{8{$past(src_word_i[7])}}, $past(src_word_i[7:0])}) else $error("bad sign fill");
  a_jump_keeps_bit: assert property (go && op inside {8'h40, 8'h41} |=> !bit_we_o)
    else $error("plain bit jump wrote the bit");
  a_atomic_plain: assert property (go && op == `OPC_ATOMIC_SEQ |=> atomic_o
    && $stable(ext_space_o) && $stable(page_override_o) && $stable(seg_override_o))
    else $error("atomic altered addressing");
  a_trap_seg_zero: assert property (go && op == `OPC_SW_TRAP |=> csp_load_o
    && csp_new_o == 8'h00 && ip_new_o == {6'h00, $past(instr_i[15:8]), 2'b00})
    else $error("trap target wrong");
endmodule
bind cpu_instruction_class_decoder cpu_class_chk #(.W(W)) u_chk (.ref_clk_i, .rst_n_i,
  .clk_en_i, .instr_valid_i, .instr_i, .src_word_i, .done_o, .illegal_trap_o, .result_o,
  .result_we_o, .bit_we_o, .ip_load_o, .ip_new_o, .csp_load_o, .csp_new_o, .push_a_o,
  .pop_cnt_o, .sw_reset_o, .watchdog_disable_o, .reset_output_pin_o, .ext_space_o,
  .page_override_o, .seg_override_o, .atomic_o);
`default_nettype wire

// *** testbench/cpu_instruction_class_decoder_tb.sv ***
// Self-checking testbench for the instruction class decoder
`timescale 1ns/1ps
`default_nettype none
`include "cpu_class_map.svh"
module cpu_instruction_class_decoder_tb;
  logic        ref_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, instr_valid_i = 1'b0;
  logic        test_bit_i = 1'b0, src_bit_i = 1'b0, cond_ok_i = 1'b0;
  logic [31:0] instr_i = 32'h0;
  logic [15:0] src_word_i = 16'h0, aux_word_i = 16'h0, ip_i = 16'h0100;
  logic [15:0] stack_top0_i = 16'h0300, stack_top1_i = 16'h0009;
  logic [7:0]  csp_i = 8'h02, csp_new_o, seg_sel_o;
  logic [15:0] result_o, ip_new_o, push_a_data_o, push_b_data_o;
  logic [9:0]  page_sel_o;
  logic [1:0]  pop_cnt_o;
  logic        done_o, illegal_trap_o, result_we_o, bit_val_o, bit_we_o, ip_load_o;
  logic        csp_load_o, push_a_o, push_b_o, sw_reset_o, idle_o, power_down_o;
  logic        watchdog_service_o, watchdog_disable_o, reset_output_pin_o, ext_space_o;
  logic        page_override_o, seg_override_o, atomic_o;
  int          failures = 0, cmp_count = 0;
  cpu_instruction_class_decoder #(.W(16)) uut (.ref_clk_i, .rst_n_i, .clk_en_i,
    .instr_valid_i, .instr_i, .src_word_i, .aux_word_i, .test_bit_i, .src_bit_i, .cond_ok_i,
    .ip_i, .csp_i, .stack_top0_i, .stack_top1_i, .done_o, .illegal_trap_o, .result_o,
    .result_we_o, .bit_val_o, .bit_we_o, .ip_load_o, .ip_new_o, .csp_load_o, .csp_new_o,
    .push_a_o, .push_a_data_o, .push_b_o, .push_b_data_o, .pop_cnt_o, .sw_reset_o, .idle_o,
    .power_down_o, .watchdog_service_o, .watchdog_disable_o, .reset_output_pin_o,
    .ext_space_o, .page_override_o, .page_sel_o, .seg_override_o, .seg_sel_o, .atomic_o);
  always #10 ref_clk_i = ~ref_clk_i;
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic issue(input logic [31:0] x, input logic [15:0] s, input logic [15:0] a,
                       input logic b, input logic c);
    @(posedge ref_clk_i);
    instr_i <= x;
    src_word_i <= s;
    aux_word_i <= a;
    test_bit_i <= b;
    src_bit_i <= b;
    cond_ok_i <= c;
    instr_valid_i <= 1'b1;
    @(posedge ref_clk_i);
    instr_valid_i <= 1'b0;
    #1;
  endtask
  task automatic run_op(input logic [31:0] x);
    issue(x, 16'h0, 16'h0, 1'b0, 1'b0);
  endtask
  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic t_system;
    chk(reset_output_pin_o, 1'b0);
    run_op(`PAT_WDT_DISABLE);
    chk(watchdog_disable_o, 1'b1);
    run_op(`PAT_END_INIT);
    chk(reset_output_pin_o, 1'b1);
    run_op(`PAT_WDT_DISABLE);
    chk({done_o, watchdog_disable_o}, 2'b10);
    run_op(`PAT_SW_RESET);
    chk(sw_reset_o, 1'b1);
    run_op(`PAT_IDLE_MODE);
    chk({idle_o, power_down_o}, 2'b10);
    run_op(`PAT_WDT_SERVICE);
    chk(watchdog_service_o, 1);
    run_op(`PAT_SW_RESET ^ 32'h80000000);
    chk({illegal_trap_o, sw_reset_o, done_o}, 3'b100);
    run_op(`PAT_SW_RESET ^ 32'h00000100);
    chk({illegal_trap_o, sw_reset_o}, 2'b10);
    run_op(32'hFFFF007C);
    chk({done_o, illegal_trap_o}, 2'b10);
  endtask
  task automatic t_bits;
    issue(32'hFE000040, 16'h0, 16'h0, 1'b1, 1'b0);
    chk({ip_load_o, bit_we_o, ip_new_o}, {2'b10, 16'h00FC});
    issue(32'hFE000041, 16'h0, 16'h0, 1'b1, 1'b0);
    chk({ip_load_o, bit_we_o}, 2'b00);
    issue(32'h02000042, 16'h0, 16'h0, 1'b1, 1'b0);
    chk({ip_load_o, bit_we_o, bit_val_o, ip_new_o}, {3'b110, 16'h0104});
    issue(32'h02000042, 16'h0, 16'h0, 1'b0, 1'b0);
    chk({ip_load_o, bit_we_o}, 2'b00);
    issue(32'h00000043, 16'h0, 16'h0, 1'b0, 1'b0);
    chk({ip_load_o, bit_we_o, bit_val_o}, 3'b111);
    issue(32'h00000010, 16'h0, 16'h0, 1'b1, 1'b0);
    chk({bit_we_o, bit_val_o}, 2'b11);
    issue(32'h00000011, 16'h0, 16'h0, 1'b1, 1'b0);
    chk({bit_we_o, bit_val_o}, 2'b10);
  endtask
  task automatic t_words;
    issue(32'h00000030, 16'h0080, 16'h0, 1'b0, 1'b0);
    chk(result_o, 16'hFF80);
    issue(32'h00000031, 16'h0080, 16'h0, 1'b0, 1'b0);
    chk(result_o, 16'h0080);
    issue(32'h00000424, 16'h8000, 16'h0, 1'b0, 1'b0);
    chk(result_o, 16'hF800);
    issue(32'h00000420, 16'h8000, 16'h0, 1'b0, 1'b0);
    chk(result_o, 16'h0800);
    issue(32'h00000123, 16'h8001, 16'h0, 1'b0, 1'b0);
    chk(result_o, 16'h0003);
    issue(32'h00000028, 16'h0100, 16'h0, 1'b0, 1'b0);
    chk(result_o, 16'h0007);
  endtask
  task automatic t_stack;
    issue(32'h00000038, 16'h1234, 16'h5678, 1'b0, 1'b0);
    chk({push_a_o, push_a_data_o, result_o}, {1'b1, 16'h1234, 16'h5678});
    issue(32'h20000054, 16'h4321, 16'h0, 1'b0, 1'b0);
    chk({ip_new_o, push_a_data_o, push_b_data_o}, {16'h2000, 16'h4321, 16'h0100});
    run_op(32'h00000062);
    chk({ip_load_o, csp_load_o, pop_cnt_o, ip_new_o}, {4'hA, 16'h0300});
  endtask
  task automatic t_flow;
    run_op(32'h00000558);
    chk({csp_load_o, push_b_o, csp_new_o, ip_new_o}, {2'b11, 8'h00, 16'h0014});
    run_op(32'h30000748);
    chk({csp_load_o, csp_new_o, ip_new_o}, {1'b1, 8'h07, 16'h3000});
    issue(32'h40000050, 16'h0, 16'h0, 1'b0, 1'b0);
    chk({done_o, ip_load_o, push_a_o}, 3'b100);
    issue(32'h40000050, 16'h0, 16'h0, 1'b0, 1'b1);
    chk({ip_load_o, ip_new_o, push_a_data_o}, {1'b1, 16'h4000, 16'h0100});
    issue(32'h02000052, 16'h0, 16'h0, 1'b0, 1'b0);
    chk({ip_load_o, push_a_o}, 2'b11);
    run_op(32'h00000061);
    chk({csp_load_o, csp_new_o, ip_new_o, pop_cnt_o}, {1'b1, 8'h09, 16'h0300, 2'h2});
    run_op(32'h00000060);
    chk({ip_load_o, csp_load_o}, 2'b10);
  endtask
  task automatic t_prefix;
    run_op(32'h01551071);
    chk({page_override_o, ext_space_o, atomic_o, page_sel_o}, {3'b101, 10'h155});
    run_op(32'h0000007C);
    chk(page_override_o, 1'b1);
    run_op(32'h0000007C);
    chk(page_override_o, 1'b0);
    run_op(32'h00330074);
    chk({seg_override_o, ext_space_o, seg_sel_o}, {2'b11, 8'h33});
    run_op(32'h0000007C);
    chk({seg_override_o, ext_space_o}, 2'b00);
    run_op(32'h00000070);
    chk(ext_space_o, 1'b1);
    run_op(32'h00000078);
    chk({atomic_o, page_override_o, seg_override_o, ext_space_o}, 4'h9);
    run_op(32'h0000007C);
    chk({done_o, atomic_o}, 2'b10);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    t_system();
    t_bits();
    t_words();
    t_stack();
    t_flow();
    t_prefix();
    final_report();
  end
  initial begin
    #20000;
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
